// File: afm_pkg.sv
// Shared constants and types for the axis fault monitor.
package afm_pkg;
	localparam int NUM_AXES      = 4;
	localparam int NUM_SWITCHES  = 4;
	localparam int CLOCK_HZ      = 25000000;
	localparam int STARTUP_MS    = 10000;
	localparam int CYCLES_PER_MS = CLOCK_HZ / 1000;
	localparam int MS_CNT_W      = 15;
	localparam int SEC_CNT_W     = 14;

	localparam int SW_NEG_HARD   = 0;
	localparam int SW_NEG_SLOW   = 1;
	localparam int SW_POS_SLOW   = 2;
	localparam int SW_POS_HARD   = 3;

	localparam logic [3:0]  SW_MASK_RESET = 4'hF;
	localparam logic [3:0]  SW_POL_RESET  = 4'hF;
	localparam logic [31:0] TIMEOUT_RESET = 32'h00000000;
	localparam logic [31:0] TIMEOUT_OFF   = 32'h00000000;
	localparam logic [7:0]  ASTATE_READY  = 8'h52;
	localparam logic [7:0]  ASTATE_TMO    = 8'h5A;
	localparam logic [7:0]  ASTATE_LIMIT  = 8'h45;
	localparam logic [7:0]  ASTATE_OFF    = 8'h49;
	localparam logic [7:0]  ASTATE_DRIVER = 8'h56;

	typedef enum logic [2:0] {
		AFM_ST_OFF,
		AFM_ST_READY,
		AFM_ST_LIMIT_FAULT,
		AFM_ST_INIT_DONE,
		AFM_ST_FAULT
	} afm_state_t;

	typedef struct packed {
		logic [3:0]  mask;
		logic [3:0]  polarity;
		logic [1:0]  refSel;
		logic [31:0] timeoutMs;
	} afm_cfg_t;

	typedef struct packed {
		logic init;
		logic release_;
		logic moving;
		logic dirPositive;
	} afm_cmd_t;
endpackage : afm_pkg

// File: afm_axis_fault_monitor.sv
// Top level of the four-axis limit, driver, timeout and stop-loop supervisor.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - Four limit inputs per axis; any one may be chosen as reference.
// - Negative hard limit during negative travel cuts motor power at once.
// - Negative slowdown switch requests a ramp; motor stays powered and controlled.
// - Positive slowdown switch acts like negative one, for positive travel only.
// - Positive hard limit cuts power like negative one, positive travel only.
// - A switch is recognised only when its mask bit is one.
// - Polarity bit clear means active low, set means active high; set by default.
// - Power stage error opens loop and disables that axis power stage.
// - Motion processor error or implausible answer shuts that axis off.
// - Each axis holds a 32-bit motion timeout in milliseconds.
// - A timeout of zero disables timeout supervision for the axis.
// - Motion running longer than the timeout shuts axis off, state Z.
// - Open stop loop blocks all motor output stages.
// - Changed axis parameters take effect when initialise executes.
// - Commands accepted only after about ten seconds of self initialisation.
// - Peripherals are detected only during start-up, never afterwards.
module afm_axis_fault_monitor
	import afm_pkg::*;
#(
	parameter int STARTUP_MS_P = STARTUP_MS
)
(
	input  wire logic                         clock,
	input  wire logic                         resetn,
	input  wire logic [NUM_AXES*4-1:0]        limitSwitchIn,
	input  wire logic [NUM_AXES-1:0]          driverErrorIn,
	input  wire logic [NUM_AXES-1:0]          motionProcErrorIn,
	input  wire logic [NUM_AXES-1:0]          peripheralPresentIn,
	input  wire logic                         stopLoopClosedIn,
	input  wire afm_cfg_t [NUM_AXES-1:0]      axisCfgIn,
	input  wire afm_cmd_t [NUM_AXES-1:0]      axisCmdIn,
	output logic [NUM_AXES-1:0]               powerEnable,
	output logic [NUM_AXES-1:0]               loopClosed,
	output logic [NUM_AXES-1:0]               rampRequest,
	output logic [NUM_AXES-1:0]               referenceActive,
	output logic [NUM_AXES*8-1:0]             axisStateCode,
	output logic [NUM_AXES-1:0]               peripheralFound,
	output logic                              commandReady
);

	logic [MS_CNT_W-1:0]  msCount_reg;
	logic                 msTick_reg;
	logic [SEC_CNT_W-1:0] startCount_reg;
	logic                 ready_reg;
	logic                 stopSync1_reg;
	logic                 stopSync2_reg;

	// Millisecond timebase shared by startup delay and motion timeouts.
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			msCount_reg <= '0;
			msTick_reg  <= 1'b0;
		end
		else if (msCount_reg == MS_CNT_W'(CYCLES_PER_MS - 1))
		begin
			msCount_reg <= '0;
			msTick_reg  <= 1'b1;
		end
		else
		begin
			msCount_reg <= msCount_reg + 1'b1;
			msTick_reg  <= 1'b0;
		end
	end

	// Host commands are ignored until the start-up wait has elapsed.
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			startCount_reg <= '0;
			ready_reg      <= 1'b0;
		end
		else if (!ready_reg && msTick_reg)
		begin
			if (startCount_reg == SEC_CNT_W'(STARTUP_MS_P - 1))
				ready_reg <= 1'b1;
			else
				startCount_reg <= startCount_reg + 1'b1;
		end
	end

	// Peripherals are latched once, on the cycle start-up completes.
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			peripheralFound <= '0;
		else if (!ready_reg && msTick_reg && startCount_reg == SEC_CNT_W'(STARTUP_MS_P - 1))
			peripheralFound <= peripheralPresentIn;
	end

	// A registered copy keeps the ready output straight from a flip-flop, one cycle behind.
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			commandReady <= 1'b0;
		else
			commandReady <= ready_reg;
	end

	// Two flops on the stop loop, since a metastable level here would flicker every stage.
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			stopSync1_reg <= 1'b0;
			stopSync2_reg <= 1'b0;
		end
		else
		begin
			stopSync1_reg <= stopLoopClosedIn;
			stopSync2_reg <= stopSync1_reg;
		end
	end

	genvar ax;
	generate
		for (ax = 0; ax < NUM_AXES; ax++)
		begin : gAxis
			logic [3:0]  swSync1_reg;
			logic [3:0]  swSync2_reg;
			logic [3:0]  swActive;
			afm_cfg_t    cfg_reg;
			afm_state_t  state_reg;
			afm_state_t  state_next;
			logic [31:0] elapsed_reg;
			logic [7:0]  code_reg;
			logic [7:0]  code_next;
			logic        negHard;
			logic        posHard;
			logic        timedOut;
			logic        initCmd;
			logic        releaseCmd;
			logic        moveCmd;

			// Contacts are not tied to this clock, so each passes two flops before any decision.
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
				begin
					swSync1_reg <= '0;
					swSync2_reg <= '0;
				end
				else
				begin
					swSync1_reg <= limitSwitchIn[ax*NUM_SWITCHES +: NUM_SWITCHES];
					swSync2_reg <= swSync1_reg;
				end
			end

			// Polarity bit set means the input reads high when active.
			assign swActive = cfg_reg.mask & ~(swSync2_reg ^ cfg_reg.polarity);

			assign initCmd    = ready_reg && axisCmdIn[ax].init;
			assign releaseCmd = ready_reg && axisCmdIn[ax].release_;
			assign moveCmd    = ready_reg && axisCmdIn[ax].moving;

			// Hard limits only count for travel toward the switch, so backing away never trips them.
			assign negHard = swActive[SW_NEG_HARD] && moveCmd && !axisCmdIn[ax].dirPositive;
			assign posHard = swActive[SW_POS_HARD] && moveCmd && axisCmdIn[ax].dirPositive;
			// A zero limit turns supervision off rather than tripping at once.
			assign timedOut = cfg_reg.timeoutMs != TIMEOUT_OFF
				&& elapsed_reg >= cfg_reg.timeoutMs;

			// Configuration only takes effect at an initialise command.
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
				begin
					cfg_reg.mask      <= SW_MASK_RESET;
					cfg_reg.polarity  <= SW_POL_RESET;
					cfg_reg.refSel    <= '0;
					cfg_reg.timeoutMs <= TIMEOUT_RESET;
				end
				else if (initCmd)
					cfg_reg <= axisCfgIn[ax];
			end

			// Elapsed motion time, counted only while a move is running.
			// It saturates at all ones so a very long move cannot wrap back under the limit.
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					elapsed_reg <= '0;
				else if (!moveCmd || state_reg != AFM_ST_READY)
					elapsed_reg <= '0;
				else if (msTick_reg && elapsed_reg != '1)
					elapsed_reg <= elapsed_reg + 1'b1;
			end

			// Stage and processor errors win over a hard limit, which wins over the timeout.
			// The most serious cause is therefore the one left in the state code.
			always_comb
			begin
				state_next = state_reg;
				code_next  = code_reg;
				case (state_reg)
					AFM_ST_OFF:
						if (initCmd)
						begin
							state_next = AFM_ST_READY;
							code_next  = ASTATE_READY;
						end
					AFM_ST_READY:
						if (driverErrorIn[ax] || motionProcErrorIn[ax])
						begin
							state_next = AFM_ST_FAULT;
							code_next  = ASTATE_DRIVER;
						end
						else if (negHard || posHard)
						begin
							state_next = AFM_ST_LIMIT_FAULT;
							code_next  = ASTATE_LIMIT;
						end
						else if (timedOut)
						begin
							state_next = AFM_ST_FAULT;
							code_next  = ASTATE_TMO;
						end
					// Initialise and then release are both needed, so one stray pulse cannot restore power.
					AFM_ST_LIMIT_FAULT:
						if (initCmd)
						begin
							state_next = AFM_ST_INIT_DONE;
							code_next  = ASTATE_OFF;
						end
					AFM_ST_INIT_DONE:
						if (releaseCmd)
						begin
							state_next = AFM_ST_READY;
							code_next  = ASTATE_READY;
						end
					// An initialise while the error still stands re-arms the axis; it faults again next edge.
					AFM_ST_FAULT:
						if (initCmd)
						begin
							state_next = AFM_ST_READY;
							code_next  = ASTATE_READY;
						end
					default:
					begin
						state_next = AFM_ST_OFF;
						code_next  = ASTATE_OFF;
					end
				endcase
			end

			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
				begin
					state_reg <= AFM_ST_OFF;
					code_reg  <= ASTATE_OFF;
				end
				else
				begin
					state_reg <= state_next;
					code_reg  <= code_next;
				end
			end

			// Outputs registered from the next state so a cut lands on the same edge.
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
				begin
					powerEnable[ax]         <= 1'b0;
					loopClosed[ax]          <= 1'b0;
					rampRequest[ax]         <= 1'b0;
					referenceActive[ax]     <= 1'b0;
					axisStateCode[ax*8 +: 8] <= ASTATE_OFF;
				end
				else
				begin
					// The stop loop gates power without touching the state, so closing it restores power.
					powerEnable[ax]  <= (state_next == AFM_ST_READY) && stopSync2_reg;
					loopClosed[ax]   <= (state_next == AFM_ST_READY) && stopSync2_reg;
					rampRequest[ax]  <= (state_next == AFM_ST_READY) && moveCmd
						&& ((swActive[SW_NEG_SLOW] && !axisCmdIn[ax].dirPositive)
						|| (swActive[SW_POS_SLOW] && axisCmdIn[ax].dirPositive));
					// The reference output follows the chosen switch in every state, for homing by the host.
					referenceActive[ax] <= swActive[cfg_reg.refSel];
					axisStateCode[ax*8 +: 8] <= code_next;
				end
			end
		end
	endgenerate

endmodule : afm_axis_fault_monitor
`default_nettype wire

// File: afm_axis_fault_monitor_asserts.sv
// Port-level checks for the axis fault monitor.
`timescale 1ns/1ns
`default_nettype none
module afm_axis_fault_monitor_asserts
	import afm_pkg::*;
(
	input wire logic                    clock,
	input wire logic                    resetn,
	input wire logic [NUM_AXES-1:0]     driverErrorIn,
	input wire logic [NUM_AXES-1:0]     motionProcErrorIn,
	input wire logic                    stopLoopClosedIn,
	input wire afm_cmd_t [NUM_AXES-1:0] axisCmdIn,
	input wire logic [NUM_AXES-1:0]     powerEnable,
	input wire logic [NUM_AXES-1:0]     loopClosed,
	input wire logic [NUM_AXES-1:0]     rampRequest,
	input wire logic [NUM_AXES*8-1:0]   axisStateCode,
	input wire logic [NUM_AXES-1:0]     peripheralFound,
	input wire logic                    commandReady
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!resetn);
	// Three cycles cover the two-stage synchroniser and the output register.
	a_stop_blocks: assert property (!stopLoopClosedIn [*3] |=> powerEnable == 4'h0)
		else $error("power on while stop loop open");
	a_loop_pairs: assert property (loopClosed == powerEnable)
		else $error("loop and power differ");
	a_driver_cuts: assert property (commandReady && driverErrorIn[2] |=>
		!powerEnable[2] && axisStateCode[23:16] == ASTATE_DRIVER) else $error("driver fault kept");
	a_proc_cuts: assert property (commandReady && motionProcErrorIn[1] |=>
		!powerEnable[1] && axisStateCode[15:8] == ASTATE_DRIVER) else $error("proc fault kept");
	a_limit_off: assert property (axisStateCode[7:0] == ASTATE_LIMIT |-> !powerEnable[0])
		else $error("limit code with power on");
	a_limit_holds: assert property (axisStateCode[7:0] == ASTATE_LIMIT && !axisCmdIn[0].init
		|=> axisStateCode[7:0] == ASTATE_LIMIT) else $error("limit fault left early");
	a_tmo_holds: assert property (axisStateCode[31:24] == ASTATE_TMO && !axisCmdIn[3].init
		|=> axisStateCode[31:24] == ASTATE_TMO && !powerEnable[3]) else $error("timeout left");
	a_loop_opens: assert property (axisStateCode[31:24] == ASTATE_TMO |-> !loopClosed[3])
		else $error("loop closed after timeout");
	a_ready_gate: assert property (!commandReady |-> powerEnable == 4'h0)
		else $error("power before ready");
	a_ready_stays: assert property (commandReady |=> commandReady)
		else $error("ready dropped");
	a_found_fixed: assert property (commandReady |=> $stable(peripheralFound))
		else $error("presence changed after start");
	c_limit: cover property (axisStateCode[7:0] == ASTATE_LIMIT);
	c_tmo: cover property (axisStateCode[31:24] == ASTATE_TMO);
	c_ramp: cover property (rampRequest[2]);
endmodule : afm_axis_fault_monitor_asserts
bind afm_axis_fault_monitor afm_axis_fault_monitor_asserts i_chk (
	.clock(clock), .resetn(resetn), .driverErrorIn(driverErrorIn),
	.motionProcErrorIn(motionProcErrorIn), .stopLoopClosedIn(stopLoopClosedIn),
	.axisCmdIn(axisCmdIn), .powerEnable(powerEnable), .loopClosed(loopClosed),
	.rampRequest(rampRequest), .axisStateCode(axisStateCode),
	.peripheralFound(peripheralFound), .commandReady(commandReady)
);
`default_nettype wire

// File: afm_stage_model.sv
// Stage model: switch contacts and power stage status lines.
`timescale 1ns/1ns
`default_nettype none
module afm_stage_model
	import afm_pkg::*;
(
	input  wire logic        clock,
	input  wire logic [15:0] activeSw,
	input  wire logic [15:0] polarity,
	input  wire logic [3:0]  stageFault,
	output logic      [15:0] limitSwitchIn,
	output logic      [3:0]  driverErrorIn
);
	// A contact wired active low reads low when actuated.
	always_ff @(posedge clock)
		limitSwitchIn <= ~(activeSw ^ polarity);
	always_ff @(posedge clock)
		driverErrorIn <= stageFault;
endmodule : afm_stage_model
`default_nettype wire

// File: afm_testbench.sv
// Self-checking bench for the axis fault monitor.
`timescale 1ns/1ns
`default_nettype none
module testbench
	import afm_pkg::*;
;
	logic            clock, resetn, stop;
	logic [3:0]      stageFault, procErr, present, initV, relV, movV, dirV, drvErr;
	logic [3:0]      powerEnable, loopClosed, rampRequest, referenceActive, peripheralFound;
	logic [15:0]     activeSw, limitSw;
	logic [31:0]     axisStateCode;
	logic            commandReady;
	afm_cfg_t [3:0]  cfg;
	afm_cmd_t [3:0]  cmd;
	int              checks = 0;
	int              mismatches = 0;
	always_comb foreach (cmd[k]) cmd[k] = '{initV[k], relV[k], movV[k], dirV[k]};
	afm_stage_model i_stage (.clock(clock), .activeSw(activeSw), .stageFault(stageFault),
		.polarity({cfg[3].polarity, cfg[2].polarity, cfg[1].polarity, cfg[0].polarity}),
		.limitSwitchIn(limitSw), .driverErrorIn(drvErr));
	afm_axis_fault_monitor #(.STARTUP_MS_P(1)) i_dut (.clock(clock), .resetn(resetn),
		.limitSwitchIn(limitSw), .driverErrorIn(drvErr), .motionProcErrorIn(procErr),
		.peripheralPresentIn(present), .stopLoopClosedIn(stop), .axisCfgIn(cfg),
		.axisCmdIn(cmd), .powerEnable(powerEnable), .loopClosed(loopClosed),
		.rampRequest(rampRequest), .referenceActive(referenceActive),
		.axisStateCode(axisStateCode), .peripheralFound(peripheralFound),
		.commandReady(commandReady));
	task tally_and_finish;
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	task chk(input string name, input logic [31:0] exp, input logic [31:0] seen);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask : cyc
	task pulse(input logic [3:0] i, input logic [3:0] r);
		initV = i;
		relV = r;
		cyc(1);
		initV = 4'h0;
		relV = 4'h0;
		// One idle cycle between commands; the parser that needs the longer gap sits upstream.
		cyc(1);
	endtask : pulse
	task t_start;
		pulse(4'hF, 4'h0);
		for (int i = 0; i < 30000 && commandReady !== 1'h1; i++) cyc(1);
		present = 4'hA;
		cyc(4);
		chk("ready", 1'h1, commandReady);
		chk("found", 4'h5, peripheralFound);
		chk("code", {4{ASTATE_OFF}}, axisStateCode);
		pulse(4'hF, 4'h0);
		chk("code", {4{ASTATE_READY}}, axisStateCode);
		chk("power", 4'hF, powerEnable);
		$display("test start done");
	endtask : t_start
	task t_hard;
		movV = 4'h3;
		dirV = 4'h3;
		activeSw = 16'h0011;
		cyc(5);
		chk("power", 4'hF, powerEnable);
		dirV = 4'h0;
		cyc(2);
		chk("code0", ASTATE_LIMIT, axisStateCode[7:0]);
		chk("power", 4'hE, powerEnable);
		chk("ref0", 1'h1, referenceActive[0]);
		movV = 4'h8;
		dirV = 4'h8;
		activeSw = 16'h8000;
		cyc(5);
		chk("code3", ASTATE_LIMIT, axisStateCode[31:24]);
		chk("ref3", 1'h1, referenceActive[3]);
		movV = 4'h0;
		activeSw = 16'h0000;
		cyc(4);
		pulse(4'h9, 4'h0);
		chk("code", {ASTATE_OFF, ASTATE_READY, ASTATE_READY, ASTATE_OFF}, axisStateCode);
		pulse(4'h0, 4'h9);
		chk("code", {4{ASTATE_READY}}, axisStateCode);
		$display("test hard limit done");
	endtask : t_hard
	task t_slow;
		movV = 4'h4;
		dirV = 4'h4;
		activeSw = 16'h0400;
		cyc(5);
		chk("ramp", 4'h4, rampRequest);
		chk("power", 4'hF, powerEnable);
		dirV = 4'h0;
		cyc(2);
		chk("ramp", 4'h0, rampRequest);
		activeSw = 16'h0600;
		cyc(5);
		chk("ramp", 4'h4, rampRequest);
		chk("power", 4'hF, powerEnable);
		movV = 4'h0;
		activeSw = 16'h0000;
		$display("test slowdown done");
	endtask : t_slow
	task t_fault;
		stageFault = 4'h4;
		procErr = 4'h2;
		cyc(3);
		chk("code", {ASTATE_DRIVER, ASTATE_DRIVER}, axisStateCode[23:8]);
		chk("power", 4'h9, powerEnable);
		chk("loop", 4'h9, loopClosed);
		stageFault = 4'h0;
		procErr = 4'h0;
		cyc(2);
		pulse(4'h6, 4'h0);
		chk("code", {4{ASTATE_READY}}, axisStateCode);
		$display("test fault done");
	endtask : t_fault
	task t_tmo;
		// A limit changed without a new initialise must not reach axis two.
		cfg[2].timeoutMs = 32'h00000001;
		movV = 4'hC;
		for (int i = 0; i < 60000 && axisStateCode[31:24] !== ASTATE_TMO; i++) cyc(1);
		chk("code3", ASTATE_TMO, axisStateCode[31:24]);
		chk("code2", ASTATE_READY, axisStateCode[23:16]);
		chk("power", 4'h7, powerEnable);
		chk("loop", 4'h7, loopClosed);
		movV = 4'h0;
		stop = 1'h0;
		cyc(5);
		chk("power", 4'h0, powerEnable);
		$display("test timeout and stop done");
	endtask : t_tmo
	initial
	begin
		clock = 1'h0;
		forever #20 clock = ~clock;
	end
	// The slowest path is start-up plus up to one timeout tick, well inside this span.
	initial
	begin
		#4000000;
		mismatches++;
		tally_and_finish;
	end
	initial
	begin
		resetn = 1'h0;
		stop = 1'h1;
		{stageFault, procErr, initV, relV, movV, dirV} = 24'h000000;
		present = 4'h5;
		activeSw = 16'h0000;
		foreach (cfg[k]) cfg[k] = '{SW_MASK_RESET, SW_POL_RESET, 2'h0, TIMEOUT_OFF};
		cfg[1].mask = 4'hE;
		cfg[3].refSel = 2'h3;
		cfg[2].polarity = 4'h0;
		cfg[3].timeoutMs = 32'h00000001;
		cyc(8);
		resetn = 1'h1;
		t_start;
		t_hard;
		t_slow;
		t_fault;
		t_tmo;
		tally_and_finish;
	end
endmodule : testbench
`default_nettype wire
